// ===== common/shcd_dec_if.sv
`timescale 1ns/1ps
interface shcd_dec_if;
   logic [7:0]          op;
   shcd_pkg::shcd_dec_s info;
   modport dec (input op, output info);
   modport use_side (output op, input info);
endinterface : shcd_dec_if

// ===== common/shcd_pkg.sv
package shcd_pkg;
   localparam int          ADDR_W      = 16;
   localparam int          DATA_W      = 16;
   localparam logic [3:0]  PTR_REG     = 4'hF;
   localparam logic [3:0]  CWA_REG     = 4'hD;
   localparam logic [15:0] PTR_ADDR    = 16'h000F;
   localparam logic [15:0] ILOG_START  = 16'h0040;
   localparam logic [15:0] ILOG_END    = 16'h005F;
   localparam int          REG_LSB     = 2;
   localparam int          REG_MSB     = 5;
   localparam logic [1:0]  FAST_RD_TOP = 2'h0;
   localparam logic [1:0]  FAST_WR_TOP = 2'h2;
   localparam logic [1:0]  FAST_LOW    = 2'h0;
   localparam int          OP_CLKS     = 8;
   localparam int          WORD_CLKS   = 16;
   localparam logic [7:0]  OP_ADD1     = 8'hD0;
   localparam logic [7:0]  OP_ADD2     = 8'hD8;
   localparam logic [7:0]  OP_ADD4     = 8'hE0;
   localparam logic [7:0]  OP_RD       = 8'h40;
   localparam logic [7:0]  OP_WR       = 8'hC0;
   localparam logic [7:0]  OP_INC_RD   = 8'h48;
   localparam logic [7:0]  OP_INC_WR   = 8'hC8;
   localparam logic [7:0]  OP_CWA_RD   = 8'h50;
   localparam logic [7:0]  OP_ILOG_RD  = 8'h58;
   localparam logic [7:0]  OP_ADD4_RD  = 8'h60;
   localparam logic [7:0]  OP_CH0_RD   = 8'h68;
   localparam logic [7:0]  OP_CH1_RD   = 8'h70;
   localparam logic [7:0]  OP_CH2_RD   = 8'h78;
   localparam logic [7:0]  OP_CH0_WR   = 8'hE8;
   localparam logic [7:0]  OP_CH1_WR   = 8'hF0;
   localparam logic [7:0]  OP_CH2_WR   = 8'hF8;

   typedef enum logic [1:0] {ACT_NONE, ACT_FAST, ACT_ADD, ACT_PTR} shcd_act_e;

   typedef struct packed {
      shcd_act_e  act;
      logic       wr;
      logic [3:0] reg_idx;
      logic [2:0] add;
      logic       chase;
      logic       cwa;
      logic       ilog;
   } shcd_dec_s;

   // step one word on, or back one inside the log ring
   function automatic logic [15:0] step_addr(input logic [15:0] a, input logic down);
      if (!down)
         return 16'(a + 16'h0001);
      else if (a == ILOG_START)
         return ILOG_END;
      else
         return 16'(a - 16'h0001);
   endfunction : step_addr
endpackage : shcd_pkg

// ===== hw/shcd_opdec.sv
`timescale 1ns/1ps
module shcd_opdec (
   shcd_dec_if.dec d
);
   function automatic shcd_pkg::shcd_dec_s decode(input logic [7:0] op);
      shcd_pkg::shcd_dec_s r;
      r         = '0;
      r.act     = shcd_pkg::ACT_NONE;
      r.reg_idx = op[shcd_pkg::REG_MSB:shcd_pkg::REG_LSB];
      case (op)
         shcd_pkg::OP_ADD1:    begin r.act = shcd_pkg::ACT_ADD; r.add = 3'h1; end
         shcd_pkg::OP_ADD2:    begin r.act = shcd_pkg::ACT_ADD; r.add = 3'h2; end
         shcd_pkg::OP_ADD4:    begin r.act = shcd_pkg::ACT_ADD; r.add = 3'h4; end
         shcd_pkg::OP_RD:      r.act = shcd_pkg::ACT_PTR;
         shcd_pkg::OP_WR:      begin r.act = shcd_pkg::ACT_PTR; r.wr = 1'b1; end
         shcd_pkg::OP_INC_RD:  begin r.act = shcd_pkg::ACT_PTR; r.add = 3'h1; end
         shcd_pkg::OP_INC_WR: begin
            r.act = shcd_pkg::ACT_PTR;
            r.wr  = 1'b1;
            r.add = 3'h1;
         end
         shcd_pkg::OP_CWA_RD:  begin r.act = shcd_pkg::ACT_PTR; r.cwa = 1'b1; end
         shcd_pkg::OP_CH0_RD:  begin r.act = shcd_pkg::ACT_PTR; r.chase = 1'b1; end
         shcd_pkg::OP_CH1_RD: begin
            r.act   = shcd_pkg::ACT_PTR;
            r.chase = 1'b1;
            r.add   = 3'h1;
         end
         shcd_pkg::OP_CH2_RD: begin
            r.act   = shcd_pkg::ACT_PTR;
            r.chase = 1'b1;
            r.add   = 3'h2;
         end
         shcd_pkg::OP_CH0_WR: begin
            r.act   = shcd_pkg::ACT_PTR;
            r.chase = 1'b1;
            r.wr    = 1'b1;
         end
         shcd_pkg::OP_CH1_WR: begin
            r.act   = shcd_pkg::ACT_PTR;
            r.chase = 1'b1;
            r.wr    = 1'b1;
            r.add   = 3'h1;
         end
         shcd_pkg::OP_CH2_WR: begin
            r.act   = shcd_pkg::ACT_PTR;
            r.chase = 1'b1;
            r.wr    = 1'b1;
            r.add   = 3'h2;
         end
         shcd_pkg::OP_ADD4_RD: begin r.act = shcd_pkg::ACT_PTR; r.add = 3'h4; end
         shcd_pkg::OP_ILOG_RD: begin r.act = shcd_pkg::ACT_PTR; r.ilog = 1'b1; end
         default: begin
            if (op[1:0] == shcd_pkg::FAST_LOW && op[7:6] == shcd_pkg::FAST_RD_TOP) begin
               r.act = shcd_pkg::ACT_FAST;
            end else if (op[1:0] == shcd_pkg::FAST_LOW && op[7:6] == shcd_pkg::FAST_WR_TOP) begin
               r.act = shcd_pkg::ACT_FAST;
               r.wr  = 1'b1;
            end else begin
               r.act = shcd_pkg::ACT_NONE;
            end
         end
      endcase
      return r;
   endfunction : decode

   assign d.info = decode(d.op);
endmodule : shcd_opdec

// ===== hw/shcd_top.sv
`timescale 1ns/1ps
module shcd_top #(
   parameter int AW = shcd_pkg::ADDR_W,
   parameter int DW = shcd_pkg::DATA_W
) (
   input  wire logic          clk_i,
   input  wire logic          rst_b_i,
   input  wire logic          clk_en_i,
   input  wire logic          cs_active_i,
   input  wire logic          op_valid_i,
   input  wire logic [7:0]    op_byte_i,
   input  wire logic          rd_req_i,
   input  wire logic          wr_valid_i,
   input  wire logic [DW-1:0] wr_word_i,
   output logic               rd_valid_o,
   output logic      [DW-1:0] rd_data_o,
   output logic               mem_rd_o,
   output logic               mem_we_o,
   output logic      [AW-1:0] mem_addr_o,
   output logic      [DW-1:0] mem_wdata_o,
   input  wire logic [DW-1:0] mem_rdata_i,
   input  wire logic [AW-1:0] cwa_i,
   input  wire logic [AW-1:0] ilog_addr_i,
   output logic      [AW-1:0] ptr_o
);
   if (AW != shcd_pkg::ADDR_W || DW != AW) begin : g_chk
      $error("shcd_top: address and data must both be 16 bits");
   end

   typedef enum logic [2:0] {S_IDLE, S_CHASE, S_LOAD, S_XFER, S_IGNORE} shcd_state_e;

   shcd_state_e         state_reg;
   shcd_state_e         state_next;
   shcd_pkg::shcd_dec_s dec_reg;
   logic [15:0]         ptr_reg;
   logic [15:0]         ptr_next;
   logic [15:0]         hid_reg;
   logic                use_hid_reg;
   logic                rd_pend_reg;
   logic                self_reg;
   logic                wr_pend_reg;
   logic                rd_valid_reg;
   logic [15:0]         self_val_reg;
   logic [15:0]         waddr_reg;
   logic [15:0]         wdata_reg;
   logic [15:0]         rd_data_reg;

   shcd_dec_if dif ();
   shcd_opdec u_dec (
      .d (dif)
   );
   assign dif.op = op_byte_i;

   wire shcd_pkg::shcd_dec_s info  = dif.info;
   wire               start   = op_valid_i && state_reg == S_IDLE && cs_active_i;
   wire [15:0]        cur     = use_hid_reg ? hid_reg : ptr_reg;
   wire               in_xfer = state_reg == S_XFER && cs_active_i;
   wire               rd_go   = in_xfer && !dec_reg.wr && rd_req_i;
   wire               wr_go   = in_xfer && dec_reg.wr && wr_valid_i;
   wire               chase_go = state_reg == S_CHASE;
   wire [15:0]        rsel    = self_reg ? self_val_reg : mem_rdata_i;
   wire [15:0]        ptr_add = 16'(ptr_reg + {13'h0, info.add});
   wire [15:0]        ilog_prev = shcd_pkg::step_addr(ilog_addr_i, 1'b1);
   wire               hid_step = (rd_go || wr_go) && use_hid_reg;
   wire [15:0]        hid_next = start ? {12'h000, info.reg_idx} : 16'(hid_reg + 16'h0001);

   assign mem_rd_o    = clk_en_i && (rd_go || chase_go);
   assign mem_addr_o  = wr_pend_reg ? waddr_reg : cur;
   assign mem_we_o    = clk_en_i && wr_pend_reg && waddr_reg != shcd_pkg::PTR_ADDR;
   assign mem_wdata_o = wdata_reg;
   assign rd_valid_o  = rd_valid_reg;
   assign rd_data_o   = rd_data_reg;
   assign ptr_o       = ptr_reg;

   always_comb begin
      state_next = state_reg;
      ptr_next   = ptr_reg;
      case (state_reg)
         S_IDLE: begin
            if (start) begin
               case (info.act)
                  shcd_pkg::ACT_FAST: state_next = S_XFER;
                  shcd_pkg::ACT_ADD: begin
                     ptr_next   = ptr_add;
                     state_next = S_IGNORE;
                  end
                  shcd_pkg::ACT_PTR: begin
                     if (info.cwa)
                        ptr_next = cwa_i;
                     else if (info.ilog)
                        ptr_next = ilog_prev;
                     else
                        ptr_next = ptr_add;
                     state_next = info.chase ? S_CHASE : S_XFER;
                  end
                  default: state_next = S_IGNORE;
               endcase
            end
         end
         S_CHASE:  state_next = S_LOAD;
         S_LOAD: begin
            ptr_next   = rsel;
            state_next = S_XFER;
         end
         S_XFER: begin
            if ((rd_go || wr_go) && !use_hid_reg)
               ptr_next = shcd_pkg::step_addr(ptr_reg, dec_reg.ilog);
         end
         S_IGNORE: state_next = S_IGNORE;
         default:  state_next = S_IDLE;
      endcase
      if (wr_pend_reg && waddr_reg == shcd_pkg::PTR_ADDR)
         ptr_next = wdata_reg;
      if (!cs_active_i)
         state_next = S_IDLE;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         state_reg <= S_IDLE;
      else if (clk_en_i)
         state_reg <= state_next;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         ptr_reg <= '0;
      else if (clk_en_i)
         ptr_reg <= ptr_next;
   end

   // opcode decode held for the whole frame
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         dec_reg <= '0;
      else if (clk_en_i && start)
         dec_reg <= info;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         use_hid_reg <= 1'b0;
      else if (clk_en_i && start)
         use_hid_reg <= info.act == shcd_pkg::ACT_FAST;
   end

   // hidden pointer for fast register access
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         hid_reg <= '0;
      else if (clk_en_i && (start || hid_step))
         hid_reg <= hid_next;
   end

   // read pipe: address out, data back, word valid
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         rd_pend_reg <= 1'b0;
      else if (clk_en_i)
         rd_pend_reg <= rd_go;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         rd_valid_reg <= 1'b0;
      else if (clk_en_i)
         rd_valid_reg <= rd_pend_reg;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         rd_data_reg <= '0;
      else if (clk_en_i && rd_pend_reg)
         rd_data_reg <= rsel;
   end

   // register 15 answers from here, not from memory
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         self_reg     <= 1'b0;
         self_val_reg <= '0;
      end else if (clk_en_i) begin
         self_reg     <= cur == shcd_pkg::PTR_ADDR;
         self_val_reg <= ptr_reg;
      end
   end

   // write pipe: address and data held one cycle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         wr_pend_reg <= 1'b0;
      else if (clk_en_i)
         wr_pend_reg <= wr_go;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         waddr_reg <= '0;
         wdata_reg <= '0;
      end else if (clk_en_i && wr_go) begin
         waddr_reg <= cur;
         wdata_reg <= wr_word_i;
      end
   end
endmodule : shcd_top

// ===== tb/shcd_mem_model.sv
`timescale 1ns/1ps
module shcd_mem_model (
   input  wire logic        clk_i,
   input  wire logic        rd_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o
);
   logic [15:0] mem [logic [15:0]];
   logic [15:0] word;
   logic        rd_q = 1'b0;
   // unwritten words hold address plus 0100; idle cycles show a flipped word
   always @(posedge clk_i) begin
      rd_q <= rd_i;
      if (we_i) mem[addr_i] = wdata_i;
      if (rd_i) word <= mem.exists(addr_i) ? mem[addr_i] : addr_i + 16'h0100;
   end
   assign rdata_o = rd_q ? word : ~word;
endmodule : shcd_mem_model

// ===== tb/shcd_monitor.sv
`timescale 1ns/1ps
module shcd_monitor (
   input wire logic        clk_i,
   input wire logic        rst_b_i,
   input wire logic        clk_en_i,
   input wire logic        cs_active_i,
   input wire logic        op_valid_i,
   input wire logic [7:0]  op_byte_i,
   input wire logic        wr_valid_i,
   input wire logic        rd_valid_o,
   input wire logic        mem_rd_o,
   input wire logic        mem_we_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [15:0] cwa_i,
   input wire logic [15:0] ilog_addr_i,
   input wire logic [15:0] ptr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // opcode arriving as the frame opens
   sequence s_op; $rose(cs_active_i) && op_valid_i && clk_en_i; endsequence
   a_read_late: assert property (
      rd_valid_o && $past(mem_addr_o, 2) != 16'h000F |-> $past(mem_rd_o, 2)) else $error("late read");
   a_write_source: assert property (
      mem_we_o |-> mem_addr_o != 16'h000F && $past(wr_valid_i)) else $error("stray write");
   a_add_step: assert property (
      s_op ##0 (op_byte_i inside {8'hD0, 8'hD8, 8'hE0}) |=> ptr_o == 16'($past(ptr_o)
      + ($past(op_byte_i[5]) ? 16'h4 : 16'h1 + 16'($past(op_byte_i[3]))))) else $error("add");
   a_inc_step: assert property (
      s_op ##0 (op_byte_i inside {8'h48, 8'h60}) |=> ptr_o == 16'($past(ptr_o)
      + ($past(op_byte_i[5]) ? 16'h4 : 16'h1))) else $error("step");
   a_cwa_load: assert property (
      s_op ##0 (op_byte_i == 8'h50) |=> ptr_o == $past(cwa_i)) else $error("cwa load");
   a_ilog_load: assert property (
      s_op ##0 (op_byte_i == 8'h58) |=> ptr_o == ($past(ilog_addr_i) == 16'h0040 ? 16'h005F
      : 16'($past(ilog_addr_i) - 16'h1))) else $error("log load");
   a_chase_fetch: assert property (
      s_op ##0 (op_byte_i inside {8'h68, 8'h70, 8'h78, 8'hE8, 8'hF0, 8'hF8}) |=> mem_rd_o
      && mem_addr_o == 16'($past(ptr_o) + $past(op_byte_i[4:3]) - 16'h1)) else $error("chase");
   a_fast_keep: assert property (
      s_op ##0 (!op_byte_i[6] && op_byte_i[1:0] == 2'h0 && op_byte_i != 8'hBC)
      |=> $stable(ptr_o)[*3]) else $error("fast moved pointer");
   c_read: cover property (rd_valid_o);
   c_write: cover property (mem_we_o);
   c_log: cover property (s_op ##0 op_byte_i == 8'h58);
endmodule : shcd_monitor

// ===== tb/spi_host_command_decoder_bench.sv
`timescale 1ns/1ps
module spi_host_command_decoder_bench;
   logic        clk_i = 1'b0, rst_b_i = 1'b0, cs_active_i = 1'b0, op_valid_i = 1'b0;
   logic        rd_req_i = 1'b0, wr_valid_i = 1'b0, rd_valid_o, mem_rd_o, mem_we_o;
   logic        clk_en_i = 1'b1;
   logic [7:0]  op_byte_i = 8'h00;
   logic [15:0] wr_word_i = 16'h0000, cwa_i = 16'h0107, ilog_addr_i = 16'h0040, p, q;
   logic [15:0] rd_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i, ptr_o;
   int          fails = 0, num_checks = 0;
   shcd_top shcd_top_i (.clk_i, .rst_b_i, .clk_en_i, .cs_active_i, .op_valid_i,
      .op_byte_i, .rd_req_i, .wr_valid_i, .wr_word_i, .rd_valid_o, .rd_data_o, .mem_rd_o,
      .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .cwa_i, .ilog_addr_i, .ptr_o);
   shcd_mem_model shcd_mem_model_i (.clk_i, .rd_i(mem_rd_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   initial forever #5 clk_i = ~clk_i;
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp) fails++;
   endtask : chk
   task automatic op(input logic [7:0] b);
      @(negedge clk_i) cs_active_i = 1'b0;
      @(negedge clk_i) {cs_active_i, op_valid_i, op_byte_i} = {2'b11, b};
      @(negedge clk_i) op_valid_i = 1'b0;
      @(negedge clk_i);
   endtask : op
   task automatic rd(input logic [16:0] e, input logic [15:0] pe);
      @(negedge clk_i) rd_req_i = 1'b1;
      @(negedge clk_i) rd_req_i = 1'b0;
      @(negedge clk_i) chk({rd_valid_o, e[16] ? rd_data_o : e[15:0]}, e);
      chk({1'b0, ptr_o}, {1'b0, pe});
   endtask : rd
   task automatic wr(input logic [15:0] d);
      @(negedge clk_i) {wr_valid_i, wr_word_i} = {1'b1, d};
      @(negedge clk_i) wr_valid_i = 1'b0;
   endtask : wr
   task automatic setp(input logic [15:0] v);
      op(8'hBC);
      wr(v);
   endtask : setp
   // clock enable low: a pending read request must not be taken
   task automatic hold_off(input logic [15:0] pe);
      @(negedge clk_i) {clk_en_i, rd_req_i} = 2'b01;
      repeat (3) @(negedge clk_i);
      chk({mem_rd_o | rd_valid_o, ptr_o}, {1'b0, pe});
      {clk_en_i, rd_req_i} = 2'b10;
   endtask : hold_off
   // span well beyond the full sequence
   initial begin
      #100000 fails++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(negedge clk_i);
      rst_b_i = 1'b1;
      setp(16'h0100);
      for (int i = 0; i < 3; i++) begin
         op(8'hD0 + 8'(i * 8));
         rd(17'h0, 16'h0100 + 16'((2 << i) - 1));
      end
      op(8'hC0);
      wr(16'h1111);
      op(8'hC8);
      wr(16'h3333);
      setp(16'h0107);
      op(8'h40);
      hold_off(16'h0107);
      rd({1'b1, 16'h1111}, 16'h0108);
      op(8'h48);
      rd({1'b1, 16'h3333}, 16'h010A);
      op(8'h60);
      rd({1'b1, 16'h020E}, 16'h010F);
      op(8'h50);
      rd({1'b1, 16'h1111}, 16'h0108);
      for (int k = 0; k < 3; k++) begin
         setp(16'h0200);
         op(8'h68 + 8'(k * 8));
         rd({1'b1, 16'h0400 + 16'(k)}, 16'h0301 + 16'(k));
         setp(16'h0200);
         op(8'hE8 + 8'(k * 8));
         wr(16'h5A50 + 16'(k));
         setp(16'h0300 + 16'(k));
         op(8'h40);
         rd({1'b1, 16'h5A50 + 16'(k)}, 16'h0301 + 16'(k));
      end
      for (int j = 0; j < 2; j++) begin
         ilog_addr_i = 16'h0040 + 16'(j * 2);
         op(8'h58);
         p = j ? 16'h0041 : 16'h005F;
         repeat (3) begin
            q = (p == 16'h0040) ? 16'h005F : p - 16'h0001;
            rd({1'b1, p + 16'h0100}, q);
            p = q;
         end
      end
      op(8'h44);
      rd(17'h0, 16'h005E);
      op(8'h8C);
      wr(16'hABCD);
      wr(16'hBCDE);
      op(8'h0C);
      rd({1'b1, 16'hABCD}, 16'h005E);
      rd({1'b1, 16'hBCDE}, 16'h005E);
      tally_and_finish();
   end
endmodule : spi_host_command_decoder_bench
bind shcd_top shcd_monitor shcd_monitor_i (.clk_i, .rst_b_i, .clk_en_i, .cs_active_i,
   .op_valid_i, .op_byte_i, .wr_valid_i, .rd_valid_o, .mem_rd_o, .mem_we_o, .mem_addr_o,
   .cwa_i, .ilog_addr_i, .ptr_o);
